// [verilog/srqc_pkg.sv]
// constants for the request-pin control block
// assumes an ahb-lite slave with 32-bit data, one word per register
package srqc_pkg;

   // ======================================================
   // register indices, byte address is four times the index
   localparam logic [7:0] SRQC_IDX_POS_LO = 8'h0b;
   localparam logic [7:0] SRQC_IDX_POS_HI = 8'h0c;
   localparam logic [7:0] SRQC_IDX_CTRL = 8'h0e;
   localparam logic [7:0] SRQC_IDX_AUX = 8'h20;
   localparam logic [31:0] SRQC_ADDR_POS_LO = {22'h0, SRQC_IDX_POS_LO, 2'b00};
   localparam logic [31:0] SRQC_ADDR_POS_HI = {22'h0, SRQC_IDX_POS_HI, 2'b00};
   localparam logic [31:0] SRQC_ADDR_CTRL = {22'h0, SRQC_IDX_CTRL, 2'b00};
   localparam logic [31:0] SRQC_ADDR_AUX = {22'h0, SRQC_IDX_AUX, 2'b00};

   // ======================================================
   // request_pin_control fields
   localparam int SRQC_CTRL_W = 16;
   localparam int SRQC_BIT_LATCH = 0;
   localparam int SRQC_BIT_FUNC = 1;
   localparam int SRQC_BIT_CAPEN = 2;
   localparam int SRQC_BIT_MUTEDIS = 8;
   localparam logic [15:0] SRQC_CTRL_RESET = 16'h0002;
   localparam logic [15:0] SRQC_CTRL_MASK = 16'h0107;
   localparam logic SRQC_FUNC_SYNC = 1'h0;

   // ======================================================
   // auxiliary control fields
   localparam int SRQC_BIT_CLEAR = 0;
   localparam int SRQC_BIT_REFEN = 1;
   localparam int SRQC_BIT_SYNCEN = 2;
   localparam int SRQC_BIT_SWREQ = 3;
   localparam logic [3:0] SRQC_AUX_RESET = 4'h1;

   // ======================================================
   // clock-position snapshot
   localparam int SRQC_SNAP_W = 32;
   localparam logic [31:0] SRQC_SNAP_RESET = 32'h0000ffff;
   localparam logic [4:0] SRQC_SNAP_LAST = 5'h1f;

   typedef enum logic [3:0] {
      SRQC_ST_IDLE = 4'h1,
      SRQC_ST_ARMED = 4'h2,
      SRQC_ST_FILL = 4'h4,
      SRQC_ST_DONE = 4'h8
   } srqc_state_t;

endpackage : srqc_pkg

// [verilog/srqc_capture.sv]
// clock-position snapshot register, filled lsb first
// assumes the sample bit is already synchronised to clk_sys
`timescale 1ns/1ps
module srqc_capture
   import srqc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // control
   input wire logic sampleBit,
   input wire logic shiftEn,
   input wire logic clearEn,
   // result
   output logic [srqc_pkg::SRQC_SNAP_W-1:0] snapshot,
   output logic done
);
   import srqc_pkg::*;

   logic [SRQC_SNAP_W-1:0] snap_reg;
   logic [SRQC_SNAP_W-1:0] snap_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;

   // ======================================================
   // per-bit fill
   genvar i;
   generate
      for (i = 0; i < SRQC_SNAP_W; i++) begin : g_bit
         always_comb begin
            if (clearEn) begin
               snap_next[i] = 1'b0;
            end else if (shiftEn && cnt_reg == 5'(i)) begin
               snap_next[i] = sampleBit;
            end else begin
               snap_next[i] = snap_reg[i];
            end
         end
      end
   endgenerate

   always_comb begin
      cnt_next = cnt_reg;
      if (clearEn) begin
         cnt_next = 5'h0;
      end else if (shiftEn) begin
         cnt_next = cnt_reg + 5'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         snap_reg <= SRQC_SNAP_RESET;
         cnt_reg <= 5'h0;
      end else begin
         snap_reg <= snap_next;
         cnt_reg <= cnt_next;
      end
   end

   assign snapshot = snap_reg;
   assign done = shiftEn && !clearEn && cnt_reg == SRQC_SNAP_LAST;

endmodule : srqc_capture

// [verilog/srqc_top.sv]
// request-pin control: pin role, request latch, mute and clock-position capture
// assumes request and clock pins are asynchronous to clk_sys; ahb-lite master
// Operation
// - in sync role the reference outputs are muted unless mute-disable is set; the code mutes only while the sync or reference enable is set.
// - a sync request also resets the reference dividers.
// - capture-enable turns on the window that snapshots the input clock after a request edge.
// - after the clear, the first request rising edge starts the capture.
// - with both sync and reference enables low the capture window stays off.
// - pin-function 0 selects sync input, 1 selects reference-request input.
// - with the latch enabled the first request rising edge holds the request high.
// - request-clear empties the latch; latch disabled means the request follows the pins; the code also holds it high while the software request bit is set.
// - request-clear resets latch, divider retimers and capture flip-flops.
// - while clear is set the request is held low except in repeater role.
// - the readback is a 32-bit snapshot filled lsb to msb, one clock sample per step.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module srqc_top
   import srqc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // pins
   input wire logic requestPins,
   input wire logic inputClockPin,
   // to the reference path
   output logic internalRequest,
   output logic referenceMute,
   output logic dividerSyncPulse,
   output logic retimerReset,
   output logic captureBusy
);
   import srqc_pkg::*;

   // ======================================================
   // pin synchronisers
   logic [1:0] reqSync_reg;
   logic [1:0] clkSync_reg;
   logic reqPrev_reg;
   logic reqRise;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reqSync_reg <= 2'h0;
         clkSync_reg <= 2'h0;
         reqPrev_reg <= 1'b0;
      end else begin
         reqSync_reg <= {reqSync_reg[0], requestPins};
         clkSync_reg <= {clkSync_reg[0], inputClockPin};
         reqPrev_reg <= reqSync_reg[1];
      end
   end
   assign reqRise = reqSync_reg[1] && !reqPrev_reg;

   // ======================================================
   // ahb-lite slave, zero wait states
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [3:0] aux_reg;
   logic [3:0] aux_next;
   logic wrPend_reg;
   logic wrPend_next;
   logic [31:0] wrAddr_reg;
   logic [31:0] wrAddr_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] snapshot;
   logic addrPhase;

   assign addrPhase = hsel && htrans[1] && hready;

   always_comb begin
      ctrl_next = ctrl_reg;
      aux_next = aux_reg;
      if (wrPend_reg) begin
         if (wrAddr_reg == SRQC_ADDR_CTRL) begin
            // reserved bits are dropped even if software sets them
            ctrl_next = hwdata[15:0] & SRQC_CTRL_MASK;
         end else if (wrAddr_reg == SRQC_ADDR_AUX) begin
            aux_next = hwdata[3:0];
         end
      end
      wrPend_next = addrPhase && hwrite;
      wrAddr_next = addrPhase ? haddr : wrAddr_reg;
      // read from next values so a write just before is seen
      rdata_next = 32'h0;
      if (addrPhase && !hwrite) begin
         if (haddr == SRQC_ADDR_CTRL) begin
            rdata_next = {16'h0, ctrl_next};
         end else if (haddr == SRQC_ADDR_AUX) begin
            rdata_next = {28'h0, aux_next};
         end else if (haddr == SRQC_ADDR_POS_LO) begin
            rdata_next = {16'h0, snapshot[15:0]};
         end else if (haddr == SRQC_ADDR_POS_HI) begin
            rdata_next = {16'h0, snapshot[31:16]};
         end else begin
            rdata_next = 32'h0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= SRQC_CTRL_RESET;
         aux_reg <= SRQC_AUX_RESET;
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 32'h0;
         rdata_reg <= 32'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         aux_reg <= aux_next;
         wrPend_reg <= wrPend_next;
         wrAddr_reg <= wrAddr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // ======================================================
   // field decode
   logic latchEn;
   logic syncRole;
   logic muteDis;
   logic clearBit;
   logic refEn;
   logic syncEn;
   logic swReq;
   logic captureOn;

   assign latchEn = ctrl_reg[SRQC_BIT_LATCH];
   assign syncRole = ctrl_reg[SRQC_BIT_FUNC] == SRQC_FUNC_SYNC;
   assign muteDis = ctrl_reg[SRQC_BIT_MUTEDIS];
   assign clearBit = aux_reg[SRQC_BIT_CLEAR];
   assign refEn = aux_reg[SRQC_BIT_REFEN];
   assign syncEn = aux_reg[SRQC_BIT_SYNCEN];
   assign swReq = aux_reg[SRQC_BIT_SWREQ];
   // capture-enable ignored when both paths are off; dropping it saves power
   assign captureOn = ctrl_reg[SRQC_BIT_CAPEN] && (syncEn || refEn);

   // ======================================================
   // request latch and outputs
   logic latch_reg;
   logic latch_next;
   logic req_reg;
   logic req_next;
   logic mute_reg;
   logic mute_next;
   logic divSync_reg;
   logic divSync_next;
   logic clearPrev_reg;

   always_comb begin
      latch_next = latch_reg;
      if (clearBit) begin
         latch_next = 1'b0;
      end else if (latchEn && reqRise) begin
         latch_next = 1'b1;
      end
      if (clearBit && syncRole) begin
         req_next = 1'b0;
      end else if (latchEn) begin
         req_next = latch_reg || (reqRise && !clearBit);
      end else begin
         req_next = reqSync_reg[1] || swReq;
      end
      mute_next = syncRole && !muteDis && (syncEn || refEn);
      // sync edge restarts the reference dividers
      divSync_next = syncRole && req_next && !req_reg;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         latch_reg <= 1'b0;
         req_reg <= 1'b0;
         mute_reg <= 1'b0;
         divSync_reg <= 1'b0;
         clearPrev_reg <= 1'b0;
      end else begin
         latch_reg <= latch_next;
         req_reg <= req_next;
         mute_reg <= mute_next;
         divSync_reg <= divSync_next;
         clearPrev_reg <= clearBit;
      end
   end

   assign internalRequest = req_reg;
   assign referenceMute = mute_reg;
   assign dividerSyncPulse = divSync_reg;
   assign retimerReset = clearBit;

   // ======================================================
   // capture window
   srqc_state_t state_reg;
   srqc_state_t state_next;
   logic capDone;
   logic shiftEn;

   assign shiftEn = state_reg == SRQC_ST_FILL;

   always_comb begin
      state_next = state_reg;
      if (!captureOn || clearBit) begin
         state_next = SRQC_ST_IDLE;
      end else begin
         case (state_reg)
            SRQC_ST_IDLE: begin
               // arming only on the falling side of a clear pulse
               if (clearPrev_reg) begin
                  state_next = SRQC_ST_ARMED;
               end
            end
            SRQC_ST_ARMED: begin
               if (reqRise) begin
                  state_next = SRQC_ST_FILL;
               end
            end
            SRQC_ST_FILL: begin
               if (capDone) begin
                  state_next = SRQC_ST_DONE;
               end
            end
            default: begin
               state_next = SRQC_ST_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= SRQC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // clock samples are one sys cycle apart; coarse stand-in for the delay line
   srqc_capture u_capture (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .sampleBit(clkSync_reg[1]),
      .shiftEn(shiftEn),
      .clearEn(clearBit),
      .snapshot(snapshot),
      .done(capDone)
   );

   assign captureBusy = state_reg != SRQC_ST_IDLE && state_reg != SRQC_ST_DONE;

   // ======================================================
   // checks
   a_mute_sync:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      (syncRole && !muteDis && (syncEn || refEn)) |=> referenceMute)
      else $error("reference outputs not muted in sync role");

   a_div_sync:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      (syncRole && !clearBit && !latchEn && reqRise && !req_reg)
      |=> dividerSyncPulse)
      else $error("sync edge did not reset dividers");

   a_func_req:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      !syncRole |=> !dividerSyncPulse)
      else $error("divider reset in request role");

   a_latch_hold:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      (latchEn && !clearBit && latch_reg) |=> internalRequest)
      else $error("latched request not held high");

   a_clear_latch:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      clearBit |=> !latch_reg)
      else $error("clear did not empty the latch");

   a_clear_low:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      (clearBit && syncRole) |=> !internalRequest)
      else $error("request not held low during clear");

   a_cap_off:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      (!syncEn && !refEn) |=> (state_reg == SRQC_ST_IDLE))
      else $error("capture window active with paths off");

   a_cap_trigger:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_reg == SRQC_ST_ARMED && reqRise && captureOn && !clearBit)
      |=> shiftEn)
      else $error("request edge did not start capture");

   a_snap_len:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      ($rose(shiftEn) && captureOn && !clearBit)
      |-> ##32 !shiftEn)
      else $error("snapshot fill not 32 samples");

   a_snap_clear:
   assert property (@(posedge clk_sys) disable iff (!rstn)
      clearBit |=> (snapshot == 32'h0))
      else $error("clear did not reset snapshot");

endmodule : srqc_top

// [sim/srqc_source.sv]
// partner model: external request source and input clock for the request pins
// assumes the bench commands the request level and the clock mode off clk_sys
`timescale 1ns/1ps
module srqc_source (
   // commands from the bench
   input wire logic reqCmd,
   input wire logic [1:0] clkMode,
   // pins
   output logic requestPins,
   output logic inputClockPin
);
   // ======================================================
   // free-running input clock, unrelated in phase to clk_sys
   logic toggleClk = 1'b0;

   initial begin
      forever #3.3 toggleClk = ~toggleClk;
   end

   // ======================================================
   // pins driven continuously; skew keeps edges off the sampling clock
   assign #2 requestPins = reqCmd;
   // mode 0 holds low, 1 holds high, 2 or 3 runs free
   assign #1 inputClockPin = clkMode[1] ? toggleClk : clkMode[0];
endmodule : srqc_source

// [sim/srqc_top_tb_top.sv]
// self-checking bench for the request-pin control block
// assumes zero-wait ahb-lite slave and a single partner model on the pins
`timescale 1ns/1ps
module srqc_top_tb_top;
   import srqc_pkg::*;
   // ======================================================
   // signals
   logic clk_sys, rstn, hsel, hwrite, reqCmd, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, clkMode;
   logic [2:0] hsize;
   logic requestPins, inputClockPin, internalRequest, referenceMute;
   logic dividerSyncPulse, retimerReset, captureBusy;
   int miscompares = 0;
   int checksDone = 0;
   int syncPulses = 0;
   logic [15:0] rows [5][2];

   srqc_top dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .requestPins(requestPins), .inputClockPin(inputClockPin),
      .internalRequest(internalRequest), .referenceMute(referenceMute),
      .dividerSyncPulse(dividerSyncPulse), .retimerReset(retimerReset),
      .captureBusy(captureBusy));

   srqc_source src (.reqCmd(reqCmd), .clkMode(clkMode), .requestPins(requestPins),
      .inputClockPin(inputClockPin));

   // ======================================================
   // clock, pulse counter, watchdog
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (dividerSyncPulse === 1'b1) syncPulses++;
   end

   // whole run is well under 3000 cycles
   initial begin
      #400000;
      miscompares++;
      $display("ERROR at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
      results();
   end

   // ======================================================
   // tasks
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chkBit(input logic got, input logic exp);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: bit got %h expected %h", $time, got, exp);
      end
   endtask : chkBit

   // one single word transfer; waits on hready, never assumes a latency
   task automatic busXfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask : busXfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      busXfer(a, 1'b1, d);
   endtask : wr

   task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
      busXfer(a, 1'b0, 32'h0);
      chk32(rd, exp);
   endtask : rdChk

   // request pulse of 8 cycles, then 8 quiet cycles
   task automatic pulse();
      @(posedge clk_sys);
      reqCmd <= 1'b1;
      repeat (8) @(posedge clk_sys);
      reqCmd <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : pulse

   task automatic results();
      $display("checks %0d, mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // ======================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      reqCmd = 1'b0;
      clkMode = 2'h2;
      rows = '{'{16'h0000, 16'h0000}, '{16'h0001, 16'h0001}, '{16'h0004, 16'h0004},
         '{16'h0100, 16'h0100}, '{16'h0107, 16'h0107}};
      repeat (4) @(posedge clk_sys);
      chkBit(retimerReset, 1'b1);
      chkBit(internalRequest, 1'b0);
      rstn <= 1'b1;
      rdChk(SRQC_ADDR_CTRL, 32'h0000_0002);
      // clear comes out of reset set, so the snapshot is emptied at once
      rdChk(SRQC_ADDR_POS_LO, 32'h0000_0000);
      rdChk(SRQC_ADDR_POS_HI, 32'h0000_0000);
      rdChk(SRQC_ADDR_AUX, 32'h0000_0001);
      rdChk(32'h0000_0040, 32'h0000_0000);
      // register rows: reserved bits always written as zero
      for (int i = 0; i < 5; i++) begin
         wr(SRQC_ADDR_CTRL, {16'h0, rows[i][0]});
         rdChk(SRQC_ADDR_CTRL, {16'h0, rows[i][1]});
      end
      // mute follows role and mute-disable
      wr(SRQC_ADDR_AUX, 32'h2);
      wr(SRQC_ADDR_CTRL, 32'h0);
      repeat (3) @(posedge clk_sys);
      chkBit(referenceMute, 1'b1);
      wr(SRQC_ADDR_CTRL, 32'h100);
      repeat (3) @(posedge clk_sys);
      chkBit(referenceMute, 1'b0);
      wr(SRQC_ADDR_CTRL, 32'h2);
      repeat (3) @(posedge clk_sys);
      chkBit(referenceMute, 1'b0);
      // unlatched sync role: request follows the pin, divider sync fires once
      wr(SRQC_ADDR_CTRL, 32'h0);
      syncPulses = 0;
      @(posedge clk_sys);
      reqCmd <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chkBit(internalRequest, 1'b1);
      chk32(32'(syncPulses), 32'h1);
      reqCmd <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chkBit(internalRequest, 1'b0);
      // latched: stays high after the pin drops, clear empties it
      wr(SRQC_ADDR_CTRL, 32'h1);
      pulse();
      chkBit(internalRequest, 1'b1);
      wr(SRQC_ADDR_AUX, 32'h3);
      repeat (3) @(posedge clk_sys);
      chkBit(internalRequest, 1'b0);
      @(posedge clk_sys);
      reqCmd <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chkBit(internalRequest, 1'b0);
      // software request bit must not override the clear either
      wr(SRQC_ADDR_AUX, 32'hb);
      repeat (3) @(posedge clk_sys);
      chkBit(internalRequest, 1'b0);
      // repeater role is not held low by clear
      wr(SRQC_ADDR_CTRL, 32'h2);
      repeat (6) @(posedge clk_sys);
      chkBit(internalRequest, 1'b1);
      reqCmd <= 1'b0;
      repeat (6) @(posedge clk_sys);
      // pin low, software bit keeps the unlatched request up
      chkBit(internalRequest, 1'b1);
      // capture with input clock held high, then low
      for (int k = 1; k >= 0; k--) begin
         clkMode <= k[1:0];
         wr(SRQC_ADDR_CTRL, 32'h6);
         wr(SRQC_ADDR_AUX, 32'h7);
         rdChk(SRQC_ADDR_POS_LO, 32'h0);
         wr(SRQC_ADDR_AUX, 32'h6);
         repeat (3) @(posedge clk_sys);
         chkBit(captureBusy, 1'b1);
         pulse();
         for (int n = 0; n < 100 && captureBusy !== 1'b0; n++) @(posedge clk_sys);
         chkBit(captureBusy, 1'b0);
         rdChk(SRQC_ADDR_POS_LO, {16'h0, {16{k[0]}}});
         rdChk(SRQC_ADDR_POS_HI, {16'h0, {16{k[0]}}});
      end
      // both enables off: capture-enable ignored
      wr(SRQC_ADDR_AUX, 32'h1);
      wr(SRQC_ADDR_AUX, 32'h0);
      repeat (3) @(posedge clk_sys);
      chkBit(captureBusy, 1'b0);
      pulse();
      chkBit(captureBusy, 1'b0);
      wr(SRQC_ADDR_CTRL, 32'h2);
      // second reset in mid-run
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      rdChk(SRQC_ADDR_CTRL, 32'h0000_0002);
      rdChk(SRQC_ADDR_POS_LO, 32'h0000_0000);
      results();
   end
endmodule : srqc_top_tb_top
